// ===== hdl/mac_flow_cfg.svh
// register offsets, field positions, reset values and timing constants
`ifndef MAC_FLOW_CFG_SVH
`define MAC_FLOW_CFG_SVH
`define PHY_MGMT_DATA_OFS     12'h118
`define PAUSE_CONTROL_OFS     12'h11c
`define VLAN_TAG_ONE_OFS      12'h120
`define MGMT_STATUS_OFS       12'h130
`define PHY_MGMT_DATA_RST     16'h0000
`define PAUSE_TIME_RST        16'h0000
`define VLAN_TAG_ONE_RST      16'hffff
`define PAUSE_TIME_LSB        16
`define PASS_CTRL_BIT         2
`define FLOW_EN_BIT           1
`define FLOW_BUSY_BIT         0
`define FRAME_MAX_PLAIN       11'd1518
`define FRAME_MAX_VLAN        11'd1522
`define QUANTUM_BITS          10'd512
`endif

// ===== hdl/mac_flow_pkg.sv
// types shared by the flow control slice
package mac_flow_pkg;
    typedef enum logic [1:0] {
        FLOW_IDLE  = 2'b00,
        FLOW_SEND  = 2'b01,
        FLOW_PRESS = 2'b10
    } flow_state_e;
endpackage

// ===== hdl/pause_timer.sv
// pause countdown in quanta of 512 bit times
`timescale 1ns/10ps
`default_nettype none
`include "mac_flow_cfg.svh"
module pause_timer #(
    parameter int QW = 16
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // control
    input  wire logic          load,
    input  wire logic [QW-1:0] quanta,
    input  wire logic          bit_tick,
    input  wire logic          enable,
    // status
    output logic               paused
);
    logic [QW-1:0] quanta_reg;
    logic [9:0]    bit_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quanta_reg <= '0;
            bit_reg    <= 10'h000;
        end else if (!enable) begin
            quanta_reg <= '0;
            bit_reg    <= 10'h000;
        end else if (load) begin
            quanta_reg <= quanta;
            bit_reg    <= 10'h000;
        end else if (quanta_reg != '0 && bit_tick) begin
            if (bit_reg == `QUANTUM_BITS - 10'd1) begin
                bit_reg    <= 10'h000;
                quanta_reg <= quanta_reg - 1'b1;
            end else begin
                bit_reg <= bit_reg + 10'd1;
            end
        end
    end

    assign paused = (quanta_reg != '0);
endmodule
`default_nettype wire

// ===== hdl/mac_pause_vlan_phydata_regs.sv
// management data, pause/back-pressure flow control and vlan_tag_one tag match
//
// How it works
// RL1: data register holds phy write/read value
// RL2: software writes data only when idle
// RL3: read data stable until busy clears
// RL4: sent control frames carry programmed pause time
// RL5: pass set flags pause frames filtered
// RL6: pass clear leaves filter bit low
// RL7: pause honored only full duplex, enabled
// RL8: all received frames go to application
// RL9: filtering modes override pass option
// RL10: pause transmitter for time times slot
// RL11: flow disabled ignores control frames
// RL12: half duplex enable means back pressure
// RL13: busy high while pause/pressure sent
// RL14: busy clears after pause frame sent
// RL15: software writes busy as zero, idle
// RL16: vlan_tag_one match on bytes 13/14
// RL17: vlan frames allow 1522 bytes
// RL18: checksum offload uses vlan_tag_one tag
// RL19: change vlan_tag_one only with rx off
// RL20: slot time is 512 bit times
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "mac_flow_cfg.svh"
module mac_pause_vlan_phydata_regs (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // phy management engine
    input  wire logic        mgmt_busy,
    input  wire logic        mgmt_rd_done,
    input  wire logic [15:0] mgmt_rd_data,
    output logic [15:0]      mgmt_wr_data,
    // mac mode
    input  wire logic        full_duplex,
    input  wire logic        filter_mode_active,
    input  wire logic        bit_tick,
    // receive stream
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_pause_ok,
    input  wire logic [15:0] rx_pause_quanta,
    input  wire logic        rx_filter_fail,
    output logic             rx_out_valid,
    output logic [7:0]       rx_out_data,
    output logic             rx_out_eof,
    output logic             rx_packet_filter,
    output logic             rx_vlan_one,
    output logic             rx_too_long,
    output logic [15:0]      rx_checksum_offload_tag,
    // transmit side
    input  wire logic        tx_pause_req,
    input  wire logic        tx_ctrl_done,
    input  wire logic        rx_congested,
    output logic             tx_send_pause,
    output logic [15:0]      tx_pause_time,
    output logic             tx_hold,
    output logic             back_pressure
);
    mac_flow_pkg::flow_state_e state_reg;
    mac_flow_pkg::flow_state_e state_next;
    logic [15:0] mgmt_data_reg;
    logic [15:0] pause_time_reg;
    logic        pass_ctrl_reg;
    logic        flow_en_reg;
    logic [15:0] vlan_tag_reg;
    logic [10:0] byte_cnt_reg;
    logic [7:0]  hi_byte_reg;
    logic        vlan_hit_reg;
    logic        paused;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && !penable && !pwrite;
    wire flow_busy = (state_reg != mac_flow_pkg::FLOW_IDLE);
    wire mapped = hit(paddr, `PHY_MGMT_DATA_OFS) || hit(paddr, `PAUSE_CONTROL_OFS)
               || hit(paddr, `VLAN_TAG_ONE_OFS) || hit(paddr, `MGMT_STATUS_OFS);

    // no wait states: setup decodes, access completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // data register; phy read result wins over a stray write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgmt_data_reg   <= `PHY_MGMT_DATA_RST;
        end else begin
            if (mgmt_rd_done) begin
                mgmt_data_reg <= mgmt_rd_data; // RL1 RL3
            end else if (wr_en && pready && hit(paddr, `PHY_MGMT_DATA_OFS) && !mgmt_busy) begin
                mgmt_data_reg <= pwdata[15:0]; // RL1 RL2
            end
        end
    end

    // writes while busy are dropped so the pause field cannot tear mid-frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_time_reg <= `PAUSE_TIME_RST;
            pass_ctrl_reg  <= 1'b0;
            flow_en_reg    <= 1'b0;
        end else if (wr_en && pready && hit(paddr, `PAUSE_CONTROL_OFS) && !flow_busy) begin
            pause_time_reg <= pwdata[31:`PAUSE_TIME_LSB]; // RL4 RL15
            pass_ctrl_reg  <= pwdata[`PASS_CTRL_BIT];
            flow_en_reg    <= pwdata[`FLOW_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vlan_tag_reg <= `VLAN_TAG_ONE_RST; // RL16
        end else if (wr_en && pready && hit(paddr, `VLAN_TAG_ONE_OFS)) begin
            vlan_tag_reg <= pwdata[15:0]; // RL19
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (hit(paddr, `PHY_MGMT_DATA_OFS)) begin
                prdata <= {16'h0000, mgmt_data_reg};
            end else if (hit(paddr, `PAUSE_CONTROL_OFS)) begin
                prdata <= {pause_time_reg, 13'h0000, pass_ctrl_reg, flow_en_reg, flow_busy};
            end else if (hit(paddr, `VLAN_TAG_ONE_OFS)) begin
                prdata <= {16'h0000, vlan_tag_reg};
            end else if (hit(paddr, `MGMT_STATUS_OFS)) begin
                prdata <= {30'h0000_0000, paused, mgmt_busy};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // flow state: full duplex sends pause frames, half duplex applies pressure
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mac_flow_pkg::FLOW_IDLE: begin
                if (flow_en_reg && full_duplex && tx_pause_req) begin
                    state_next = mac_flow_pkg::FLOW_SEND;
                end else if (flow_en_reg && !full_duplex && rx_congested) begin
                    state_next = mac_flow_pkg::FLOW_PRESS; // RL12
                end
            end
            mac_flow_pkg::FLOW_SEND: begin
                if (tx_ctrl_done) begin
                    state_next = mac_flow_pkg::FLOW_IDLE; // RL14
                end
            end
            mac_flow_pkg::FLOW_PRESS: begin
                if (!rx_congested || !flow_en_reg || full_duplex) begin
                    state_next = mac_flow_pkg::FLOW_IDLE;
                end
            end
            default: state_next = mac_flow_pkg::FLOW_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= mac_flow_pkg::FLOW_IDLE;
        end else begin
            state_reg <= state_next; // RL13
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_send_pause <= 1'b0;
            tx_pause_time <= 16'h0000;
            back_pressure <= 1'b0;
            tx_hold       <= 1'b0;
            mgmt_wr_data  <= 16'h0000;
            rx_checksum_offload_tag <= `VLAN_TAG_ONE_RST;
        end else begin
            tx_send_pause  <= (state_next == mac_flow_pkg::FLOW_SEND); // RL13
            tx_pause_time  <= pause_time_reg; // RL4
            back_pressure  <= (state_next == mac_flow_pkg::FLOW_PRESS); // RL12
            tx_hold        <= paused; // RL10
            mgmt_wr_data   <= mgmt_data_reg;
            rx_checksum_offload_tag <= vlan_tag_reg; // RL18
        end
    end

    // pause decode only when enabled in full duplex
    wire pause_take = rx_eof && rx_valid && rx_pause_ok && flow_en_reg && full_duplex; // RL7 RL11

    pause_timer #(.QW(16)) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (pause_take),
        .quanta  (rx_pause_quanta),
        .bit_tick(bit_tick), // RL20
        .enable  (flow_en_reg && full_duplex), // RL10 RL11
        .paused  (paused)
    );

    // frame byte counter and vlan_tag_one match on bytes 13 and 14
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_cnt_reg <= 11'd0;
            hi_byte_reg  <= 8'h00;
            vlan_hit_reg <= 1'b0;
        end else if (rx_valid) begin
            if (rx_sof) begin
                byte_cnt_reg <= 11'd1;
                vlan_hit_reg <= 1'b0;
            end else if (byte_cnt_reg != 11'h7ff) begin
                byte_cnt_reg <= byte_cnt_reg + 11'd1;
            end
            if (byte_cnt_reg == 11'd12) begin
                hi_byte_reg <= rx_data;
            end
            if (byte_cnt_reg == 11'd13) begin
                vlan_hit_reg <= ({hi_byte_reg, rx_data} == vlan_tag_reg); // RL16
            end
        end
    end

    wire [10:0] len_max = vlan_hit_reg ? `FRAME_MAX_VLAN : `FRAME_MAX_PLAIN; // RL17
    wire [10:0] len_now = rx_sof ? 11'd1 : byte_cnt_reg + 11'd1;

    // every byte passes through; status tells software what to drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_out_valid     <= 1'b0;
            rx_out_data      <= 8'h00;
            rx_out_eof       <= 1'b0;
            rx_packet_filter <= 1'b0;
            rx_vlan_one      <= 1'b0;
            rx_too_long      <= 1'b0;
        end else begin
            rx_out_valid <= rx_valid; // RL8
            rx_out_data  <= rx_data;
            rx_out_eof   <= rx_valid && rx_eof;
            if (rx_valid && rx_eof) begin
                rx_vlan_one <= vlan_hit_reg;
                rx_too_long <= (len_now > len_max); // RL17
                if (filter_mode_active) begin
                    rx_packet_filter <= rx_filter_fail; // RL9
                end else begin
                    rx_packet_filter <= rx_pause_ok && pass_ctrl_reg; // RL5 RL6
                end
            end
        end
    end

    a_busy_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == mac_flow_pkg::FLOW_SEND) && tx_ctrl_done |=> !flow_busy) // RL14
        else $error("busy did not clear after pause frame");
    a_filter_pass: assert property (@(posedge pclk) disable iff (!presetn)
        rx_valid && rx_eof && !filter_mode_active |=> rx_packet_filter == $past(rx_pause_ok && pass_ctrl_reg)) // RL5
        else $error("filter bit wrong for pause frame");
    a_no_pause_off: assert property (@(posedge pclk) disable iff (!presetn)
        !flow_en_reg |=> ##1 !tx_hold) // RL11
        else $error("transmitter held while flow disabled");
    a_busy_send: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == mac_flow_pkg::FLOW_SEND) |-> tx_send_pause) // RL13
        else $error("busy but no pause send");
    a_pause_field: assert property (@(posedge pclk) disable iff (!presetn)
        tx_send_pause && $past(tx_send_pause) |-> tx_pause_time == pause_time_reg) // RL4
        else $error("pause time field mismatch");
    a_vlan_reset: assert property (@(posedge pclk) $rose(presetn) |-> vlan_tag_reg == 16'hffff) // RL16
        else $error("vlan tag reset wrong");
    a_press_half: assert property (@(posedge pclk) disable iff (!presetn)
        back_pressure |-> $past(!full_duplex)) // RL12
        else $error("back pressure in full duplex");
    a_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
        mgmt_busy && !mgmt_rd_done |=> $stable(mgmt_data_reg)) // RL3
        else $error("data changed during management access");
endmodule
`default_nettype wire

// ===== verif/link_partner_model.sv
// link partner: receive byte stream source and control frame completion
`timescale 1ns/10ps
`default_nettype none
module link_partner_model #(
    parameter int DONE_DLY = 20
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // frame request from the bench
    input  wire logic        go,
    input  wire logic [10:0] len,
    input  wire logic [15:0] tag,
    input  wire logic        pause_ok,
    input  wire logic [15:0] quanta,
    input  wire logic        fail,
    output logic             busy,
    // receive stream into the mac
    output logic             rx_valid,
    output logic             rx_sof,
    output logic             rx_eof,
    output logic [7:0]       rx_data,
    output logic             rx_pause_ok,
    output logic [15:0]      rx_pause_quanta,
    output logic             rx_filter_fail,
    // control frame transmit
    input  wire logic        tx_send_pause,
    output logic             tx_ctrl_done
);
    int         i;
    logic [7:0] cnt;
    initial begin
        {busy, rx_valid, rx_sof, rx_eof, rx_pause_ok, rx_filter_fail} = '0;
        rx_data = 8'h00;
        rx_pause_quanta = 16'h0000;
    end
    // rx_data toggles while idle so a stale byte never looks valid
    always begin
        @(posedge pclk);
        if (go) begin
            busy <= 1'b1;
            for (i = 1; i <= int'(len); i++) begin
                rx_valid <= 1'b1;
                rx_sof <= (i == 1);
                rx_eof <= (i == int'(len));
                rx_data <= (i == 13) ? tag[15:8] : (i == 14) ? tag[7:0] : 8'(i);
                rx_pause_ok <= (i == int'(len)) & pause_ok;
                rx_pause_quanta <= (i == int'(len)) ? quanta : ~quanta;
                rx_filter_fail <= (i == int'(len)) & fail;
                @(posedge pclk);
            end
            {rx_valid, rx_sof, rx_eof, busy} <= '0;
        end
        rx_data <= ~rx_data;
    end
    // control frame takes a while on the wire before it reports done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            tx_ctrl_done <= 1'b0;
        end else begin
            tx_ctrl_done <= (cnt == 8'(DONE_DLY));
            cnt <= (tx_send_pause && cnt <= 8'(DONE_DLY)) ? cnt + 8'h01 : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ===== verif/mac_pause_vlan_phydata_regs_tb_top.sv
// testbench for the management data, flow control and vlan_tag_one slice
`timescale 1ns/10ps
`default_nettype none
module mac_pause_vlan_phydata_regs_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, mgmt_busy = 0, mgmt_rd_done = 0, full_duplex = 1;
    logic [15:0] mgmt_rd_data = 16'h0, mgmt_wr_data, rx_pause_quanta, rx_checksum_offload_tag;
    logic        filter_mode_active = 0, bit_tick = 0, rx_valid, rx_sof, rx_eof;
    logic [7:0]  rx_data, rx_out_data;
    logic        rx_pause_ok, rx_filter_fail, rx_out_valid, rx_out_eof, rx_packet_filter;
    logic        rx_vlan_one, rx_too_long, tx_pause_req = 0, tx_ctrl_done, rx_congested = 0;
    logic        tx_send_pause, tx_hold, back_pressure, go = 0, pause_ok = 0, fail = 0, busy;
    logic [15:0] tx_pause_time, tag = 16'h0, quanta = 16'h0;
    logic [10:0] len = 11'd64;
    logic [31:0] rd;
    logic        err;
    int          fails = 0, samples_checked = 0, out_cnt = 0, n;
    always #20 pclk = ~pclk;
    always @(posedge pclk) bit_tick <= ~bit_tick;
    always @(posedge pclk) if (rx_out_valid === 1'b1) out_cnt++;
    mac_pause_vlan_phydata_regs DUT (.*);
    link_partner_model partner (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (fails == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bound(input int k);
        if (k >= 1200) begin
            chk(32'h0, 32'h1);
            test_done();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 1200; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        bound(k);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic send(input int l, input logic [15:0] t, input logic p, input logic f);
        out_cnt = 0;
        @(posedge pclk);
        {len, tag, pause_ok, quanta, fail, go} <= {11'(l), t, p, 16'h0001, f, 1'b1};
        @(posedge pclk) go <= 1'b0;
        for (n = 0; n < 2000; n++) begin
            @(negedge pclk);
            if (busy === 1'b0) break;
        end
        chk(n < 2000, 1'b1);
        repeat (3) @(negedge pclk);
        chk(out_cnt, l);
    endtask
    task automatic t_reset;
        rdchk(12'h118, 32'h0);
        rdchk(12'h120, 32'h0000ffff);
        chk(rx_checksum_offload_tag, 16'hffff);
        rdchk(12'h200, 32'h0);
        chk(err, 1'b1);
    endtask
    task automatic t_data;
        apb(1'b1, 12'h118, 32'h1234abcd);
        rdchk(12'h118, 32'h0000abcd);
        chk(mgmt_wr_data, 16'habcd);
        mgmt_busy <= 1'b1;
        apb(1'b1, 12'h118, 32'h00005555);
        rdchk(12'h118, 32'h0000abcd);
        {mgmt_rd_data, mgmt_rd_done} <= {16'h9876, 1'b1};
        @(posedge pclk) mgmt_rd_done <= 1'b0;
        mgmt_busy <= 1'b0;
        rdchk(12'h118, 32'h00009876);
    endtask
    task automatic t_txpause;
        apb(1'b1, 12'h11c, 32'h00a50002);
        tx_pause_req <= 1'b1;
        for (n = 0; n < 1200 && tx_send_pause !== 1'b1; n++) @(negedge pclk);
        bound(n);
        tx_pause_req <= 1'b0;
        chk(tx_pause_time, 16'h00a5);
        rdchk(12'h11c, 32'h00a50003);
        apb(1'b1, 12'h11c, 32'h0);
        for (n = 0; n < 1200 && tx_send_pause !== 1'b0; n++) @(negedge pclk);
        bound(n);
        rdchk(12'h11c, 32'h00a50002);
    endtask
    task automatic t_rxpause;
        apb(1'b1, 12'h11c, 32'h00000006);
        send(64, 16'h0102, 1'b1, 1'b0);
        chk(rx_packet_filter, 1'b1);
        chk(tx_hold, 1'b1);
        for (n = 0; n < 1200 && tx_hold === 1'b1; n++) @(negedge pclk);
        // one quantum is 512 bit ticks, a tick every second cycle
        chk(n > 1010 && n < 1030, 1'b1);
    endtask
    task automatic t_modes;
        full_duplex <= 1'b0;
        apb(1'b1, 12'h11c, 32'h00010002);
        send(64, 16'h0102, 1'b1, 1'b0);
        chk(rx_packet_filter, 1'b0);
        chk(tx_hold, 1'b0);
        rx_congested <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(back_pressure, 1'b1);
        rdchk(12'h11c, 32'h00010003);
        rx_congested <= 1'b0;
        full_duplex <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b1, 12'h11c, 32'h00010004);
        filter_mode_active <= 1'b1;
        send(64, 16'h0102, 1'b1, 1'b0);
        chk(rx_packet_filter, 1'b0);
        chk(tx_hold, 1'b0);
        filter_mode_active <= 1'b0;
    endtask
    task automatic t_vlan;
        apb(1'b1, 12'h120, 32'h00008100);
        rdchk(12'h120, 32'h00008100);
        chk(rx_checksum_offload_tag, 16'h8100);
        send(1522, 16'h8100, 1'b0, 1'b0);
        chk({rx_vlan_one, rx_too_long}, 2'b10);
        send(1519, 16'h8101, 1'b0, 1'b0);
        chk({rx_vlan_one, rx_too_long}, 2'b01);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_data();
        t_txpause();
        t_rxpause();
        t_modes();
        t_vlan();
        test_done();
    end
endmodule
`default_nettype wire
